/* File: core/adc_link_pkg.sv */
// Shared constants, carriers and states of the two-wire converter slave.
// Assumes a 125 MHz core clock and a serial clock that comes from the bus master.
package adc_link_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int CONV_TIME_NS = 40;
   // Least conversion time, rounded up to whole core cycles
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CONV_LOAD = 4'(CONV_CYCLES);
   localparam logic [3:0] CONV_LAST = 4'h1;

   // ************************************************************
   // Widths, codes and reset values
   // ************************************************************
   localparam int RESULT_W = 10;
   localparam int FIFO_DEPTH = 4;
   localparam logic [3:0] DEVICE_CODE = 4'h5; // Arbitrary value
   localparam logic [2:0] STRAP_RST = 3'h0;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_NIBBLE = 3'h4;
   localparam logic [3:0] ZERO_NIBBLE = 4'h0;
   localparam logic [1:0] PAD_BITS = 2'h3;
   localparam logic [7:0] SHIFT_RST = 8'hff;
   localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;

   // ************************************************************
   // Carriers and states
   // ************************************************************
   typedef struct packed {
      logic [3:0] code;
      logic [2:0] sel;
      logic rd;
   } addr_byte_t;

   typedef struct packed {
      logic [3:0] upper;
      logic [5:0] lower;
   } result_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK_ADDR = 7'h04,
      ST_HIGH = 7'h08,
      ST_ACK1 = 7'h10,
      ST_LOW = 7'h20,
      ST_ACK2 = 7'h40
   } link_state_t;

endpackage

/* File: core/adc_two_wire_read_slave.sv */
// Two-wire read slave of a 10-bit converter, with its result FIFO.
// Assumes scl comes from the bus master and may stop between frames; the
// converter core delivers conv_code on clk and holds it at the end of a conversion.
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Result FIFO
// ************************************************************
module adc_result_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic in_valid, // Write request
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word written
   output logic out_valid, // A word is waiting
   input wire logic out_ready, // Reader takes the word
   output logic [WIDTH-1:0] out_data // Oldest word
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   wire logic push = in_valid && in_ready;
   wire logic pop = out_valid && out_ready;

   // Full and empty come from the occupancy count
   assign in_ready = count != FULL_CNT;
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];

   // Storage has no reset; only pointers and count need one
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointer and occupancy update
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
         end
         count <= count + CW'(push) - CW'(pop);
      end
   end

   chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
      count <= FULL_CNT)
      else $error("fifo reports room while full");
endmodule

// ************************************************************
// Top: serial slave and conversion control
// ************************************************************
module adc_two_wire_read_slave
   import adc_link_pkg::*;
(
   input wire logic clk, // Core clock, 125 MHz
   input wire logic rst_n, // Reset, active low
   input wire logic scl, // Serial clock from the master
   input wire logic sda_i, // Data line level
   output logic sda_o, // Data line drive value, always low
   output logic sda_oe_n, // Low while pulling the data line
   input wire logic [2:0] addr_strap, // Select bits of the address
   input wire logic [RESULT_W-1:0] conv_code, // Converter output code
   output logic sample_pulse, // One-cycle start of sample and hold
   output logic conv_busy // Conversion in progress
);

   // ************************************************************
   // Start detection, clocked by the data line
   // ************************************************************
   logic start_tog;

   // A falling data line while scl is high marks a start
   always_ff @(negedge sda_i or negedge rst_n) begin
      if (!rst_n) begin
         start_tog <= 1'b0;
      end else if (scl) begin
         start_tog <= ~start_tog;
      end
   end

   // ************************************************************
   // Link domain on scl
   // ************************************************************
   link_state_t state;
   link_state_t next_state;
   logic [2:0] bit_cnt;
   logic [2:0] next_bits;
   logic next_release;
   logic next_rd;
   logic conv_fire;
   logic [7:0] addr_sr;
   logic start_seen;
   logic rd_mode;
   logic conv_tog;
   logic [2:0] strap_s1;
   logic [2:0] strap_s2;
   logic rt_s1;
   logic rt_s2;
   logic rt_seen;
   logic [RESULT_W-1:0] latest;
   logic [RESULT_W-1:0] tx_word;
   logic res_tog;
   logic [RESULT_W-1:0] hold_word;

   // Decode of the received byte and of the output bytes
   addr_byte_t rx_addr;
   result_t tx_res;
   result_t hi_src;
   assign rx_addr = addr_byte_t'(addr_sr);
   assign tx_res = result_t'(tx_word);
   wire logic start_new = start_tog != start_seen;
   wire logic addr_match = rx_addr.code == DEVICE_CODE && rx_addr.sel == strap_s2;
   wire logic byte_end = bit_cnt == BIT_LAST;
   wire logic ack_bit = addr_sr[0];
   wire logic [2:0] cnt_inc = bit_cnt + 3'h1;
   wire logic [2:0] tx_idx = BIT_LAST - cnt_inc;
   wire logic latch_now = state == ST_HIGH && cnt_inc == BIT_NIBBLE && !start_new;
   assign hi_src = latch_now ? result_t'(latest) : tx_res;
   wire logic [7:0] byte_hi = {ZERO_NIBBLE, hi_src.upper};
   wire logic [7:0] byte_lo = {tx_res.lower, PAD_BITS};

   // Incoming bits, including the master's acknowledge, sampled on the rise
   always_ff @(posedge scl or negedge rst_n) begin
      if (!rst_n) begin
         addr_sr <= SHIFT_RST;
      end else begin
         addr_sr <= {addr_sr[6:0], sda_i};
      end
   end

   // Sequence of a frame; all line changes happen on the fall
   always_comb begin
      next_state = state;
      next_bits = bit_cnt;
      next_release = sda_oe_n;
      next_rd = rd_mode;
      conv_fire = 1'b0;
      if (start_new) begin
         next_state = ST_ADDR;
         next_bits = BIT_FIRST;
         next_release = 1'b1;
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_release = 1'b1;
            end
            ST_ADDR: begin
               if (!byte_end) begin
                  next_bits = cnt_inc;
               end else if (addr_match) begin
                  next_state = ST_ACK_ADDR;
                  next_release = 1'b0;
                  next_rd = rx_addr.rd;
                  conv_fire = rx_addr.rd;
               end else begin
                  next_state = ST_IDLE;
               end
            end
            ST_ACK_ADDR: begin
               if (rd_mode) begin
                  next_state = ST_HIGH;
                  next_bits = BIT_FIRST;
                  next_release = byte_hi[7];
               end else begin
                  next_state = ST_IDLE;
                  next_release = 1'b1;
               end
            end
            ST_HIGH: begin
               if (!byte_end) begin
                  next_bits = cnt_inc;
                  next_release = byte_hi[tx_idx];
               end else begin
                  next_state = ST_ACK1;
                  next_release = 1'b1;
               end
            end
            ST_ACK1: begin
               if (!ack_bit) begin
                  next_state = ST_LOW;
                  next_bits = BIT_FIRST;
                  next_release = tx_res.lower[5];
               end else begin
                  next_state = ST_IDLE;
                  next_release = 1'b1;
               end
            end
            ST_LOW: begin
               if (!byte_end) begin
                  next_bits = cnt_inc;
                  next_release = byte_lo[tx_idx];
               end else begin
                  next_state = ST_ACK2;
                  next_release = 1'b1;
                  conv_fire = 1'b1;
               end
            end
            ST_ACK2: begin
               if (!ack_bit) begin
                  next_state = ST_HIGH;
                  next_bits = BIT_FIRST;
                  next_release = byte_hi[7];
               end else begin
                  next_state = ST_IDLE;
                  next_release = 1'b1;
               end
            end
         endcase
      end
   end

   // Falling-edge state; reset is asynchronous since scl may stand still
   always_ff @(negedge scl or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bit_cnt <= BIT_FIRST;
         sda_oe_n <= 1'b1;
         sda_o <= 1'b0;
         rd_mode <= 1'b0;
         start_seen <= 1'b0;
         conv_tog <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bits;
         sda_oe_n <= next_release;
         rd_mode <= next_rd;
         start_seen <= start_tog;
         conv_tog <= conv_tog ^ conv_fire;
      end
   end

   // Result arrival from the core; the held word is stable until acknowledged
   always_ff @(negedge scl or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1 <= STRAP_RST;
         strap_s2 <= STRAP_RST;
         rt_s1 <= 1'b0;
         rt_s2 <= 1'b0;
         rt_seen <= 1'b0;
         latest <= RESULT_RST;
         tx_word <= RESULT_RST;
      end else begin
         strap_s1 <= addr_strap;
         strap_s2 <= strap_s1;
         rt_s1 <= res_tog;
         rt_s2 <= rt_s1;
         if (rt_s2 != rt_seen) begin
            latest <= hold_word;
            rt_seen <= rt_s2;
         end
         if (latch_now) begin
            tx_word <= latest;
         end
      end
   end

   // ************************************************************
   // Core domain: conversion timing and result hand-off
   // ************************************************************
   logic cv_s1;
   logic cv_s2;
   logic cv_s3;
   logic req_pend;
   logic [3:0] conv_cnt;
   logic ack_s1;
   logic ack_s2;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [RESULT_W-1:0] fifo_out_data;

   // A conversion waits while the FIFO is full, which stalls new samples
   wire logic conv_edge = cv_s2 ^ cv_s3;
   wire logic conv_start = req_pend && !conv_busy && fifo_in_ready;
   wire logic conv_done = conv_busy && conv_cnt == CONV_LAST;
   wire logic hand_free = ack_s2 == res_tog;
   wire logic hand_load = fifo_out_valid && hand_free;

   adc_result_fifo #(
      .WIDTH(RESULT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(conv_done),
      .in_ready(fifo_in_ready),
      .in_data(conv_code),
      .out_valid(fifo_out_valid),
      .out_ready(hand_free),
      .out_data(fifo_out_data)
   );

   // Synchronisers and request flag; a new request wins over the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cv_s1 <= 1'b0;
         cv_s2 <= 1'b0;
         cv_s3 <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         req_pend <= 1'b0;
      end else begin
         cv_s1 <= conv_tog;
         cv_s2 <= cv_s1;
         cv_s3 <= cv_s2;
         ack_s1 <= rt_seen;
         ack_s2 <= ack_s1;
         req_pend <= conv_edge || (req_pend && !conv_start);
      end
   end

   // Conversion timer driven by the on-chip clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_busy <= 1'b0;
         conv_cnt <= '0;
         sample_pulse <= 1'b0;
      end else begin
         sample_pulse <= conv_start;
         if (conv_start) begin
            conv_busy <= 1'b1;
            conv_cnt <= CONV_LOAD;
         end else if (conv_busy) begin
            conv_busy <= !conv_done;
            conv_cnt <= conv_cnt - 4'h1;
         end
      end
   end

   // Word hand-off toward the link, one word per acknowledge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         res_tog <= 1'b0;
         hold_word <= RESULT_RST;
      end else if (hand_load) begin
         res_tog <= ~res_tog;
         hold_word <= fifo_out_data;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   chk_read_starts_conv: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_ADDR && byte_end && addr_match && rx_addr.rd && !start_new
      |=> conv_tog != $past(conv_tog))
      else $error("read address did not request a conversion");
   chk_sample_conv_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(conv_busy) |-> sample_pulse ##0 conv_busy [*5] ##1 !conv_busy)
      else $error("sample pulse or conversion length wrong");
   chk_addr_ack_low: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_ADDR && byte_end && addr_match && !start_new |=> !sda_oe_n)
      else $error("matching address not acknowledged");
   chk_upper_zeros: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_HIGH && bit_cnt < BIT_NIBBLE |-> !sda_oe_n)
      else $error("leading bits of first byte not zero");
   chk_upper_bits: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_HIGH && bit_cnt >= BIT_NIBBLE
      |-> sda_oe_n == tx_word[4'h9 - {1'b0, bit_cnt - BIT_NIBBLE}])
      else $error("upper result bits wrong");
   chk_lower_bits: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_LOW && bit_cnt < 3'h6 |-> sda_oe_n == tx_word[3'h5 - bit_cnt])
      else $error("lower result bits wrong");
   chk_next_sample: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_LOW && byte_end && !start_new
      |=> conv_tog != $past(conv_tog) && state == ST_ACK2)
      else $error("back-to-back sample not started");
   chk_poll_release: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_ACK_ADDR && !rd_mode && !start_new
      |=> sda_oe_n && state == ST_IDLE && $stable(conv_tog))
      else $error("poll did not release the line");
   chk_repeat_read: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_ACK2 && !ack_bit && !start_new |=> state == ST_HIGH ##1 !sda_oe_n)
      else $error("acknowledge after second byte did not repeat");
   chk_idle_quiet: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_IDLE |-> sda_oe_n)
      else $error("line driven while not addressed");
   chk_word_held: assert property (@(negedge scl) disable iff (!rst_n)
      state == ST_LOW || (state == ST_HIGH && bit_cnt >= BIT_NIBBLE) |=> $stable(tx_word))
      else $error("result changed while shifting");

   cov_read_frame: cover property (@(negedge scl) disable iff (!rst_n)
      state == ST_ACK1 && ack_bit ##1 state == ST_IDLE);
   cov_poll: cover property (@(negedge scl) disable iff (!rst_n)
      state == ST_ACK_ADDR && !rd_mode);
   cov_back_to_back: cover property (@(negedge scl) disable iff (!rst_n)
      state == ST_ACK2 && !ack_bit);
   cov_fifo_full: cover property (@(posedge clk) disable iff (!rst_n)
      req_pend && !fifo_in_ready);
endmodule

`default_nettype wire

/* File: sim/two_wire_master_model.sv */
// Behavioural two-wire bus master that faces the converter slave.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none

module two_wire_master_model #(
   parameter int HALF_NS = 32
) (
   output logic scl, // Serial clock, stands high outside frames
   output logic sda_pull_n, // Low while the master pulls the data line
   input wire logic sda // Resolved data line level
);
   // ************************************************************
   // Bus idle
   // ************************************************************
   // Clock stands still and the line is released between frames
   initial begin
      scl = 1'b1;
      sda_pull_n = 1'b1;
   end

   // ************************************************************
   // Bit-level cycles
   // ************************************************************
   // Data changes only in the low phase, so a bit never looks like a start
   task automatic bit_cycle(input logic tx, output logic rx);
      #(HALF_NS / 4) sda_pull_n = tx;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      #(HALF_NS / 2) rx = sda;
      #(HALF_NS / 2) scl = 1'b0;
   endtask

   // Start or repeated start: line falls while the clock is high
   task automatic start();
      #(HALF_NS / 4) sda_pull_n = 1'b1;
      #(HALF_NS / 4) scl = 1'b1;
      #(HALF_NS / 2) sda_pull_n = 1'b0;
      #(HALF_NS) scl = 1'b0;
   endtask

   // Stop: line rises while the clock is high, then the clock stays high
   task automatic stop();
      #(HALF_NS / 4) sda_pull_n = 1'b0;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      #(HALF_NS / 2) sda_pull_n = 1'b1;
   endtask

   // ************************************************************
   // Byte-level transfers
   // ************************************************************
   // Address byte out, line released during the acknowledge pulse
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic rx;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i], rx);
      end
      bit_cycle(1'b1, ack);
   endtask

   // Data byte in, then low to ask for more or high to end the read
   task automatic recv_byte(input logic ack_n, output logic [7:0] b);
      logic rx;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, b[i]);
      end
      bit_cycle(ack_n, rx);
   endtask
endmodule

`default_nettype wire

/* File: sim/adc_two_wire_read_slave_test.sv */
// Self-checking bench for the two-wire converter slave and its result FIFO.
// Assumes the master model drives the serial side; the bench plays the converter core.
`timescale 1ns/1ns
`default_nettype none

module adc_two_wire_read_slave_test;
   import adc_link_pkg::*;

   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic clk, rst_n, scl, sda_pull_n, sda, sda_o, sda_oe_n, sample_pulse, conv_busy;
   logic [2:0] addr_strap;
   logic [RESULT_W-1:0] conv_code;
   int error_cnt = 0;
   int tests_run = 0;
   int pulses = 0;
   int busy_cycles = 0;

   // Open-drain line with pull-up: low if either party pulls
   assign sda = sda_pull_n & (sda_oe_n | sda_o);

   adc_two_wire_read_slave uut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_strap(addr_strap), .conv_code(conv_code),
      .sample_pulse(sample_pulse), .conv_busy(conv_busy));
   two_wire_master_model m (.scl(scl), .sda_pull_n(sda_pull_n), .sda(sda));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   // Converter stand-in: a fresh code per sample, so stale results show up
   function automatic logic [RESULT_W-1:0] code_of(input int n);
      return 10'(32'h0000_03c9 + 32'(n) * 32'h0000_00b3);
   endfunction
   always @(negedge clk) begin
      if (sample_pulse === 1'b1) begin
         pulses = pulses + 1;
         conv_code <= code_of(pulses);
      end
      if (conv_busy === 1'b1) busy_cycles = busy_cycles + 1;
   end

   // ************************************************************
   // Compare and closing tasks
   // ************************************************************
   task automatic check_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ************************************************************
   // Shared frame pieces
   // ************************************************************
   task automatic address(input logic [3:0] code, input logic [2:0] sel, input logic rd,
                          output logic ack);
      m.start();
      m.send_byte({code, sel, rd}, ack);
   endtask

   // Two data bytes; the sample count tells which conversion they must carry
   task automatic get_result(input logic ack_n, input int exp_pulses);
      logic [7:0] b1, b2;
      logic [RESULT_W-1:0] exp;
      m.recv_byte(1'b0, b1);
      check_byte("sample count", 8'(exp_pulses), 8'(pulses));
      exp = code_of(pulses);
      check_byte("upper byte", {ZERO_NIBBLE, exp[9:6]}, b1);
      m.recv_byte(ack_n, b2);
      check_byte("lower byte", {exp[5:0], PAD_BITS}, b2);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_single_read();
      logic ack;
      int p;
      p = pulses;
      address(DEVICE_CODE, addr_strap, 1'b1, ack);
      check_bit("read address ack", 1'b0, ack);
      get_result(1'b1, p + 1);
      m.stop();
   endtask

   // Acknowledged lower bytes chain conversions, 18 scl cycles apart
   task automatic t_continuous();
      logic ack;
      int p;
      p = pulses;
      address(DEVICE_CODE, addr_strap, 1'b1, ack);
      check_bit("chain address ack", 1'b0, ack);
      get_result(1'b0, p + 1);
      get_result(1'b0, p + 2);
      get_result(1'b1, p + 3);
      m.stop();
   endtask

   // Write address: acknowledge, release, no sample; restart then reads
   task automatic t_poll();
      logic ack, rx;
      int p;
      p = pulses;
      address(DEVICE_CODE, addr_strap, 1'b0, ack);
      check_bit("poll ack", 1'b0, ack);
      m.bit_cycle(1'b1, rx);
      check_bit("line after poll", 1'b1, rx);
      check_byte("poll samples", 8'(p), 8'(pulses));
      address(DEVICE_CODE, addr_strap, 1'b1, ack);
      check_bit("restart ack", 1'b0, ack);
      get_result(1'b1, p + 1);
      m.stop();
   endtask

   // Wrong code or wrong select bits: line stays released, nothing sampled
   task automatic t_mismatch();
      logic ack;
      logic [7:0] b;
      logic [3:0] codes [2];
      logic [2:0] sels [2];
      int p;
      codes = '{DEVICE_CODE ^ 4'h8, DEVICE_CODE};
      sels = '{addr_strap, addr_strap ^ 3'h2};
      p = pulses;
      for (int i = 0; i < 2; i++) begin
         address(codes[i], sels[i], 1'b1, ack);
         check_bit("foreign address ack", 1'b1, ack);
         m.recv_byte(1'b0, b);
         check_byte("foreign byte", 8'hff, b);
         m.stop();
      end
      check_byte("foreign samples", 8'(p), 8'(pulses));
   endtask

   // Every select-bit setting answers to its own address
   task automatic t_straps();
      logic ack;
      for (int s = 0; s < 8; s++) begin
         @(negedge clk) addr_strap = 3'(s);
         address(DEVICE_CODE, 3'(s), 1'b0, ack);
         check_bit("strap poll ack", 1'b0, ack);
         m.stop();
      end
   endtask

   // A chain as long as the FIFO is deep: every word arrives fresh and in order
   task automatic t_fifo_chain();
      logic ack;
      int p;
      p = pulses;
      address(DEVICE_CODE, addr_strap, 1'b1, ack);
      check_bit("chain path ack", 1'b0, ack);
      for (int i = 1; i <= FIFO_DEPTH; i++) begin
         get_result(i == FIFO_DEPTH, p + i);
      end
      m.stop();
      repeat (40) @(negedge clk);
      check_bit("busy after chain", 1'b0, conv_busy);
      check_bit("pulse after chain", 1'b0, sample_pulse);
      check_byte("chain samples", 8'(p + FIFO_DEPTH + 1), 8'(pulses));
      check_bit("line after chain", 1'b1, sda);
      check_bit("drive value", 1'b0, sda_o);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial begin
      rst_n = 1'b1;
      addr_strap = 3'h5;
      conv_code = code_of(0);
      // Reset falls after time zero so the scl-clocked flops see its edge
      @(negedge clk) rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_single_read();
      t_continuous();
      t_poll();
      t_mismatch();
      t_straps();
      repeat (40) @(negedge clk);
      check_byte("busy cycles", 8'(CONV_CYCLES * pulses), 8'(busy_cycles));
      t_fifo_chain();
      conclude();
   end

   // Frames take about 23 us in all; this leaves ample margin
   initial begin
      #300000;
      error_cnt++;
      $display("MISMATCH watchdog expected done seen hang");
      conclude();
   end
endmodule

`default_nettype wire
